// ===== rtl/adcs_map.svh
/*
  Constants of the converter control block: byte layouts, reset values, counts.
  Assumes it is included by bare name from the top module.
*/
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH
`define ADCS_SETUP_RST 8'h82
`define ADCS_CONFIG_RST 8'h01
`define ADCS_KIND_BIT 7
`define ADCS_SU_REF_HI 6
`define ADCS_SU_REF_LO 5
`define ADCS_SU_REF_PWR 4
`define ADCS_SU_CLK_SRC 3
`define ADCS_SU_POLARITY 2
`define ADCS_SU_RESET_N 1
`define ADCS_SU_MON_EXT 0
`define ADCS_CF_SCAN_HI 6
`define ADCS_CF_SCAN_LO 5
`define ADCS_CF_CH_HI 2
`define ADCS_CF_CH_LO 1
`define ADCS_CF_INPUT_TYPE 0
`define ADCS_MON_BYTES 4'hd
`define ADCS_REPEAT_COUNT 4'h8
`define ADCS_LAST_CH 3'h3
`endif

// ===== rtl/adcs_mem_if.sv
/*
  Carrier between the control logic and its result memory.
  Assumes one clock domain; read data lag the address by one clock.
*/
`timescale 1ns/1ns
interface adcs_mem_if #(parameter int AW = 3, parameter int DW = 12);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ===== rtl/adcs_pin_sync.sv
/*
  Three-stage pin synchroniser; output follows once stages two and three agree.
  Assumes asynchronous pins and an idle-high bus after reset.
*/
`timescale 1ns/1ns
module adcs_pin_sync
  import adcs_pkg::*;
#(
  parameter int W = 2
)(
  // Clocking
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Pins
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1, s2, s3;
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          level[i] <= 1'b1;
        end
        else if (ce)
        begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            level[i] <= s3;
        end
      end
    end
  endgenerate
endmodule // adcs_pin_sync

// ===== rtl/adcs_pkg.sv
/*
  Types of the converter control block.
  Assumes the map header sits beside it.
*/
package adcs_pkg;
  typedef enum logic [6:0] {
    BUS_IDLE = 7'h01, BUS_ADDR = 7'h02, BUS_ACK = 7'h04, BUS_WBYTE = 7'h08,
    BUS_RBYTE = 7'h10, BUS_RACK = 7'h20, BUS_SKIP = 7'h40
  } adcs_bus_state_type;
  typedef enum logic [2:0] {SEQ_IDLE = 3'h1, SEQ_ARM = 3'h2, SEQ_BUSY = 3'h4} adcs_seq_state_type;
  typedef enum logic [1:0] {
    SCAN_RANGE = 2'h0, SCAN_REPEAT = 2'h1, SCAN_MONITOR = 2'h2, SCAN_SINGLE = 2'h3
  } adcs_scan_type;
endpackage

// ===== rtl/adcs_result_mem.sv
/*
  Result memory: one word per stored conversion, registered read data.
  Assumes the carrier interface and a shared clock enable.
*/
`timescale 1ns/1ns
module adcs_result_mem
  import adcs_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 12
)(
  // Clocking
  input wire logic sys_clk,
  input wire logic ce,
  // Access
  adcs_mem_if.mem port
);
  logic [DW-1:0] store [DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (ce && port.wr_en)
      store[port.wr_addr] <= port.wr_data;
    if (ce)
      port.rd_data <= store[port.rd_addr];
  end
endmodule // adcs_result_mem

// ===== rtl/adcs_top.sv
/*
  Converter control: two-wire slave port, setup/configuration decode,
  scan sequencer and ordered result readout.
  Assumes the analog core answers conv_start with conv_done on sys_clk,
  and an external pull-up resolves the data pin from sda_oe_n.
*/
// Functional notes
// - Channel-3 pin used as reference is skipped in multichannel scans.
// - Results stored in conversion order and read back in that order.
// - A read cycle starts the sequence using the current scan select.
// - Scan 00: convert channel 0 up to the selected upper channel.
// - Scan 01: convert the selected channel eight times, eight results.
// - Scan 10: repeat scanning channel 0 to upper channel continuously.
// - Scan 11: one conversion of the selected channel, one result.
// - Reference select pair decodes supply, external, internal, internal driven out.
// - Bit 4 keeps internal reference powered; off for supply or external.
// - Bit 3 picks internal oscillator or serial clock for conversions.
// - Bit 2 picks bipolar for differential; single-ended always unipolar.
// - Bit 1 at zero releases interrupt and resets configuration byte only.
// - Bit 0 set accepts up to thirteen more monitor-setup bytes.
// - Setup byte has MSB one; power-on value 0x82.
// - Single-ended: channel pick selects input 0..3 against ground.
// - Differential: pick selects pairs 0/1, 1/0, 2/3, 3/2.
// - Read: start, 7-bit address, read bit; matching address acknowledged.
// - Each result goes out as two bytes, each acknowledged by master.
// - First byte: 1, channel tag, 0, 1, 1, top two data bits.
// - Second byte low data bits; ack continues, nack releases data line.
// - Written byte with MSB 0 is configuration, MSB 1 is setup.
// - Configuration: scan 6:5, channel 2:1, input type 0; power-on 0x01.
`timescale 1ns/1ns
`include "adcs_map.svh"
module adcs_top
  import adcs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h34,
  parameter int DEPTH = 8,
  parameter int AW = 3
)(
  // Clocking
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Analog core
  output logic conv_start,
  output logic [1:0] conv_pos,
  output logic [1:0] conv_neg,
  output logic conv_diff,
  output logic conv_bipolar,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  // Reference and monitor controls
  output logic [1:0] ref_mode,
  output logic ref_internal_on,
  output logic shared_ch3_ref_pin,
  output logic conv_clock_ext,
  output logic int_release,
  output logic [7:0] mon_ctrl,
  output logic seq_busy
);
  adcs_mem_if #(.AW(AW), .DW(12)) mem_bus ();
  adcs_result_mem #(.DEPTH(DEPTH), .AW(AW), .DW(12)) u_mem (
    .sys_clk(sys_clk),
    .ce(ce),
    .port(mem_bus.mem)
  );

  logic [1:0] pins;
  adcs_pin_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .pin({scl_in, sda_in}),
    .level(pins)
  );

  // Stored bytes
  logic [7:0] setup_control_byte;
  logic [7:0] config_byte;
  logic [3:0] mon_left;

  wire scan_select_hi = config_byte[`ADCS_CF_SCAN_HI];
  wire scan_select_lo = config_byte[`ADCS_CF_SCAN_LO];
  wire channel_pick_hi = config_byte[`ADCS_CF_CH_HI];
  wire channel_pick_lo = config_byte[`ADCS_CF_CH_LO];
  wire input_type_select = config_byte[`ADCS_CF_INPUT_TYPE];
  wire ref_source_hi = setup_control_byte[`ADCS_SU_REF_HI];
  wire ref_source_lo = setup_control_byte[`ADCS_SU_REF_LO];
  wire polarity_select = setup_control_byte[`ADCS_SU_POLARITY];
  wire conversion_clock_source = setup_control_byte[`ADCS_SU_CLK_SRC];
  wire [1:0] pick = {channel_pick_hi, channel_pick_lo};
  wire adcs_scan_type scan = adcs_scan_type'({scan_select_hi, scan_select_lo});

  // Bus line events
  logic scl_d, sda_d;
  wire scl_s = pins[1];
  wire sda_s = pins[0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

  adcs_bus_state_type bus_st;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic rw;
  logic ack_drv;
  logic hi_byte;
  logic [7:0] tx;
  logic master_ack;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic go;

  wire [7:0] rx_byte = {shreg[6:0], sda_s};
  wire addr_hit = (rx_byte[7:1] == SLAVE_ADDR);
  wire [9:0] rd_val = mem_bus.rd_data[9:0];
  wire [1:0] rd_tag = mem_bus.rd_data[11:10];
  wire [7:0] hi_out = {1'b1, rd_tag, 1'b0, 2'b11, rd_val[9:8]};
  wire [7:0] lo_out = rd_val[7:0];
  assign mem_bus.rd_addr = rd_ptr;

  // Bus engine
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_st <= BUS_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      ack_drv <= 1'b0;
      hi_byte <= 1'b1;
      tx <= 8'h00;
      master_ack <= 1'b0;
      rd_ptr <= '0;
      go <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end
    else if (ce)
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      go <= 1'b0;
      if (start_c)
      begin
        bus_st <= BUS_ADDR;
        bit_cnt <= 3'h0;
        sda_oe_n <= 1'b1;
      end
      else if (stop_c)
      begin
        bus_st <= BUS_IDLE;
        sda_oe_n <= 1'b1;
      end
      else
      begin
        unique case (bus_st)
          BUS_IDLE, BUS_SKIP: ;
          BUS_ADDR, BUS_WBYTE:
            if (scl_rise)
            begin
              shreg <= rx_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
              begin
                ack_drv <= 1'b0;
                if (bus_st == BUS_WBYTE)
                  bus_st <= BUS_ACK;
                else if (addr_hit)
                begin
                  bus_st <= BUS_ACK;
                  rw <= rx_byte[0];
                  go <= rx_byte[0];
                  hi_byte <= 1'b1;
                  if (rx_byte[0])
                    rd_ptr <= '0;
                end
                else
                  bus_st <= BUS_SKIP;
              end
            end
          BUS_ACK:
            if (scl_fall && !ack_drv)
            begin
              ack_drv <= 1'b1;
              sda_oe_n <= 1'b0;
            end
            else if (scl_fall)
            begin
              bit_cnt <= 3'h0;
              if (rw)
              begin
                bus_st <= BUS_RBYTE;
                tx <= hi_out;
                sda_oe_n <= hi_out[7];
              end
              else
              begin
                bus_st <= BUS_WBYTE;
                sda_oe_n <= 1'b1;
              end
            end
          BUS_RBYTE:
            if (scl_fall)
            begin
              if (bit_cnt == 3'h7)
              begin
                bus_st <= BUS_RACK;
                sda_oe_n <= 1'b1;
              end
              else
              begin
                bit_cnt <= bit_cnt + 3'h1;
                tx <= {tx[6:0], 1'b0};
                sda_oe_n <= tx[6];
              end
            end
          BUS_RACK:
            if (scl_rise)
              master_ack <= ~sda_s;
            else if (scl_fall)
            begin
              bit_cnt <= 3'h0;
              if (!master_ack)
                bus_st <= BUS_SKIP;
              else
              begin
                bus_st <= BUS_RBYTE;
                hi_byte <= ~hi_byte;
                tx <= hi_byte ? lo_out : hi_out;
                sda_oe_n <= hi_byte ? lo_out[7] : hi_out[7];
                // Step early so registered read data settle before the next high byte
                if (hi_byte)
                  rd_ptr <= rd_ptr + AW'(1);
              end
            end
          default:
            bus_st <= BUS_IDLE;
        endcase
      end
    end
  end

  // Written bytes
  wire byte_in = ce && bus_st == BUS_WBYTE && scl_rise && bit_cnt == 3'h7 && !start_c && !stop_c;
  wire is_setup = rx_byte[`ADCS_KIND_BIT];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_control_byte <= `ADCS_SETUP_RST;
      config_byte <= `ADCS_CONFIG_RST;
      mon_left <= 4'h0;
      mon_ctrl <= 8'h00;
      int_release <= 1'b0;
    end
    else if (ce)
    begin
      int_release <= 1'b0;
      if (start_c || stop_c)
        mon_left <= 4'h0;
      else if (byte_in && mon_left != 4'h0)
      begin
        mon_left <= mon_left - 4'h1;
        if (mon_left == `ADCS_MON_BYTES)
          mon_ctrl <= rx_byte;
      end
      else if (byte_in && is_setup)
      begin
        setup_control_byte <= rx_byte;
        if (!rx_byte[`ADCS_SU_RESET_N])
        begin
          config_byte <= `ADCS_CONFIG_RST;
          int_release <= 1'b1;
        end
        if (rx_byte[`ADCS_SU_MON_EXT])
          mon_left <= `ADCS_MON_BYTES;
      end
      else if (byte_in)
        config_byte <= rx_byte;
    end
  end

  // Scan sequencer
  adcs_seq_state_type seq_st;
  logic [2:0] ch;
  logic [3:0] done_cnt;
  wire multi = (scan == SCAN_RANGE) || (scan == SCAN_MONITOR);
  wire [2:0] step = input_type_select ? 3'h1 : 3'h2;
  wire [2:0] upper_raw = {1'b0, pick};
  wire [2:0] upper_ref = input_type_select ? 3'h2 : 3'h1;
  wire [2:0] upper = (ref_source_lo && upper_raw > upper_ref) ? upper_ref : upper_raw;
  wire [2:0] first_ch = multi ? 3'h0 : upper_raw;
  wire [2:0] ch_next = ch + step;
  wire range_end = ch_next > upper || ch_next > `ADCS_LAST_CH;
  wire clk_ok = !conversion_clock_source || scl_rise;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_st <= SEQ_IDLE;
      ch <= 3'h0;
      done_cnt <= 4'h0;
      wr_ptr <= '0;
      conv_start <= 1'b0;
      conv_pos <= 2'h0;
      conv_neg <= 2'h0;
      conv_diff <= 1'b0;
      conv_bipolar <= 1'b0;
      seq_busy <= 1'b0;
    end
    else if (ce)
    begin
      conv_start <= 1'b0;
      if (go)
      begin
        seq_st <= SEQ_ARM;
        ch <= first_ch;
        done_cnt <= 4'h0;
        wr_ptr <= '0;
        seq_busy <= 1'b1;
      end
      else
      begin
        unique case (seq_st)
          SEQ_IDLE: ;
          SEQ_ARM:
            if (clk_ok)
            begin
              seq_st <= SEQ_BUSY;
              conv_start <= 1'b1;
              conv_pos <= ch[1:0];
              conv_neg <= input_type_select ? 2'h0 : (ch[1:0] ^ 2'h1);
              conv_diff <= ~input_type_select;
              conv_bipolar <= polarity_select & ~input_type_select;
            end
          SEQ_BUSY:
            if (conv_done)
            begin
              wr_ptr <= wr_ptr + AW'(1);
              done_cnt <= done_cnt + 4'h1;
              seq_st <= SEQ_ARM;
              unique case (scan)
                SCAN_RANGE:
                  if (range_end)
                    seq_st <= SEQ_IDLE;
                  else
                    ch <= ch_next;
                SCAN_REPEAT:
                  if (done_cnt == `ADCS_REPEAT_COUNT - 4'h1)
                    seq_st <= SEQ_IDLE;
                SCAN_MONITOR:
                  ch <= range_end ? 3'h0 : ch_next;
                SCAN_SINGLE:
                  seq_st <= SEQ_IDLE;
              endcase
            end
          default:
            seq_st <= SEQ_IDLE;
        endcase
      end
      if (!go && seq_st == SEQ_BUSY && conv_done && scan != SCAN_MONITOR)
        seq_busy <= !(scan == SCAN_SINGLE || (scan == SCAN_RANGE && range_end) ||
          (scan == SCAN_REPEAT && done_cnt == `ADCS_REPEAT_COUNT - 4'h1));
    end
  end

  assign mem_bus.wr_en = ce && seq_st == SEQ_BUSY && conv_done && !go;
  assign mem_bus.wr_addr = wr_ptr;
  assign mem_bus.wr_data = {conv_pos, conv_result};

  // Reference and clock controls
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_mode <= 2'h0;
      ref_internal_on <= 1'b0;
      shared_ch3_ref_pin <= 1'b0;
      conv_clock_ext <= 1'b0;
    end
    else if (ce)
    begin
      ref_mode <= {ref_source_hi, ref_source_lo};
      ref_internal_on <= ref_source_hi & setup_control_byte[`ADCS_SU_REF_PWR];
      shared_ch3_ref_pin <= ref_source_lo;
      conv_clock_ext <= conversion_clock_source;
    end
  end
endmodule // adcs_top

// ===== test/adcs_host_model.sv
/*
  Two-wire bus master model: start, stop, byte write and byte read.
  Assumes a pull-up on the data wire; sda_rel low pulls it low.
*/
`timescale 1ns/1ns
module adcs_host_model (
  // Wire
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // Longer high phase gives slow conversions time, no stretching exists
  int hi_ext = 0;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Long low phase: the slave's answer lags a falling SCL by about five clocks
  task automatic clk_bit(input logic b, output logic s);
    sda_rel = b;
    #200 scl = 1'b1;
    #(90 + hi_ext) s = sda;
    #10 scl = 1'b0;
    #100;
  endtask
  task automatic bus_start;
    // Keep wire changes off the system clock edges during a frame
    #10 sda_rel = 1'b1;
    #100 scl = 1'b1;
    #200 sda_rel = 1'b0;
    #200 scl = 1'b0;
    #100;
  endtask
  task automatic bus_stop;
    sda_rel = 1'b0;
    #100 scl = 1'b1;
    #200 sda_rel = 1'b1;
    #190;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], ack_n);
    clk_bit(1'b1, ack_n);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, b[i]);
    clk_bit(last, s);
  endtask
endmodule // adcs_host_model

// ===== test/adcs_top_chk.sv
/*
  Port checker of the converter control top.
  Assumes one clock domain; bound onto adcs_top below.
*/
`timescale 1ns/1ns
module adcs_top_chk (
  // Clocking
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Converter
  input wire logic conv_start,
  input wire logic [1:0] conv_pos,
  input wire logic [1:0] conv_neg,
  input wire logic conv_diff,
  input wire logic conv_bipolar,
  // Controls
  input wire logic [1:0] ref_mode,
  input wire logic ref_internal_on,
  input wire logic shared_ch3_ref_pin,
  input wire logic int_release,
  input wire logic seq_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_pin_follows;
    shared_ch3_ref_pin == ref_mode[0];
  endproperty
  a_pin_follows:
    assert property (p_pin_follows) else $error("shared pin differs from reference select");
  property p_ref_power;
    ref_internal_on |-> ref_mode[1];
  endproperty
  a_ref_power:
    assert property (p_ref_power) else $error("internal reference on without internal select");
  property p_se_unipolar;
    conv_start && !conv_diff |-> !conv_bipolar;
  endproperty
  a_se_unipolar:
    assert property (p_se_unipolar) else $error("single-ended conversion marked bipolar");
  property p_diff_pair;
    conv_start && conv_diff |-> conv_neg == (conv_pos ^ 2'h1);
  endproperty
  a_diff_pair:
    assert property (p_diff_pair) else $error("differential pair mismatch");
  property p_busy_start;
    $rose(seq_busy) |-> ##[0:40] conv_start;
  endproperty
  a_busy_start:
    assert property (p_busy_start) else $error("sequence began without a conversion");
  property p_release_pulse;
    int_release |=> !int_release;
  endproperty
  a_release_pulse:
    assert property (p_release_pulse) else $error("release pulse too long");
  property p_drive_low;
    !sda_oe_n |-> !sda_out;
  endproperty
  a_drive_low:
    assert property (p_drive_low) else $error("data line driven high");
  property p_edge_align;
    $changed(sda_oe_n) |-> !$past(scl_in, 2);
  endproperty
  a_edge_align:
    assert property (p_edge_align) else $error("data line changed outside clock low");
endmodule // adcs_top_chk

bind adcs_top adcs_top_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .conv_start(conv_start), .conv_pos(conv_pos), .conv_neg(conv_neg),
  .conv_diff(conv_diff), .conv_bipolar(conv_bipolar), .ref_mode(ref_mode), .ref_internal_on(ref_internal_on),
  .shared_ch3_ref_pin(shared_ch3_ref_pin), .int_release(int_release), .seq_busy(seq_busy));

// ===== test/adcs_top_test.sv
/*
  Self-checking bench of the converter control top with a bus master model.
  Assumes the analog core answers two cycles after each conversion start.
*/
`timescale 1ns/1ns
module adcs_top_test;
  typedef struct packed {
    logic [7:0] su;
    logic [7:0] cfg;
    logic [3:0] n;
    logic [15:0] tags;
    logic [1:0] neg;
    logic bip, refon, pin, ext;
  } adcs_row_type;
  localparam logic [6:0] ADDR = 7'h34;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic conv_done = 1'b0;
  logic [9:0] conv_result = 10'h000;
  logic scl, sda_rel, sda, sda_out, sda_oe_n, conv_start, conv_diff, conv_bipolar;
  logic ref_internal_on, shared_pin, clk_ext, int_release, seq_busy, last_bip;
  logic [1:0] conv_pos, conv_neg, ref_mode, last_neg;
  logic [7:0] mon_ctrl;
  int n_fail = 0, n_compared = 0, n_conv = 0, n_rel = 0, cycles = 0, wait_cnt = 0;
  adcs_row_type rows [9];
  assign sda = sda_rel & (sda_oe_n | sda_out);
  adcs_host_model host (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  adcs_top #(.SLAVE_ADDR(ADDR)) DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_start(conv_start), .conv_pos(conv_pos),
    .conv_neg(conv_neg), .conv_diff(conv_diff), .conv_bipolar(conv_bipolar), .conv_done(conv_done),
    .conv_result(conv_result), .ref_mode(ref_mode), .ref_internal_on(ref_internal_on),
    .shared_ch3_ref_pin(shared_pin), .conv_clock_ext(clk_ext), .int_release(int_release),
    .mon_ctrl(mon_ctrl), .seq_busy(seq_busy));
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [9:0] data_of(input int n);
    return 10'(10'h2c3 ^ (n * 41));
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Analog core stand-in and hang guard
  always @(posedge sys_clk)
  begin
    conv_done <= 1'b0;
    if (wait_cnt == 1)
    begin
      conv_done <= 1'b1;
      conv_result <= data_of(n_conv);
      n_conv <= n_conv + 1;
    end
    wait_cnt <= conv_start ? 1 : 0;
    if (conv_start)
    begin
      last_neg <= conv_neg;
      last_bip <= conv_bipolar;
    end
    if (int_release)
      n_rel <= n_rel + 1;
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic write_bytes(input logic [31:0] b, input int n);
    logic a;
    host.bus_start();
    host.put_byte({ADDR, 1'b0}, a);
    check({7'h0, a}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      host.put_byte(b[31 - 8 * i -: 8], a);
      check({7'h0, a}, 8'h00);
    end
    host.bus_stop();
  endtask
  task automatic read_run(input int n, input logic [15:0] tags);
    logic a;
    logic [7:0] hi, lo;
    logic [9:0] v;
    n_conv = 0;
    host.hi_ext = 400;
    host.bus_start();
    host.put_byte({ADDR, 1'b1}, a);
    host.hi_ext = 0;
    check({7'h0, a}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      v = data_of(i);
      host.get_byte(1'b0, hi);
      check(hi, {1'b1, tags[2 * i +: 2], 3'b011, v[9:8]});
      host.get_byte(i == n - 1, lo);
      check(lo, v[7:0]);
    end
    host.bus_stop();
    check({7'h0, sda_oe_n}, 8'h01);
  endtask
  initial
  begin
    logic a;
    logic [7:0] d;
    int k;
    rows = '{
      {8'h82, 8'h07, 4'd4, 16'h00e4, 6'b000000},
      {8'ha2, 8'h07, 4'd3, 16'h0024, 6'b000010},
      {8'hd2, 8'h25, 4'd8, 16'haaaa, 6'b000100},
      {8'hfa, 8'h63, 4'd1, 16'h0001, 6'b000111},
      {8'h86, 8'h66, 4'd1, 16'h0003, 6'b101000},
      {8'h86, 8'h67, 4'd1, 16'h0003, 6'b000000},
      {8'h82, 8'h04, 4'd2, 16'h0008, 6'b110000},
      {8'hc2, 8'h61, 4'd1, 16'h0000, 6'b000000},
      {8'h86, 8'h62, 4'd1, 16'h0001, 6'b001000}};
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    foreach (rows[i])
    begin
      write_bytes({rows[i].cfg, rows[i].su, 16'h0}, 2);
      read_run(rows[i].n, rows[i].tags);
      check({ref_mode, ref_internal_on, shared_pin, clk_ext, 3'h0},
        {rows[i].su[6:5], rows[i].refon, rows[i].pin, rows[i].ext, 3'h0});
      check({5'h0, rows[i].cfg[0] ? 2'h0 : last_neg, last_bip}, {5'h0, rows[i].neg, rows[i].bip});
    end
    // Foreign address is left unanswered
    host.bus_start();
    host.put_byte({ADDR ^ 7'h01, 1'b1}, a);
    check({7'h0, a}, 8'h01);
    host.bus_stop();
    // Setup with reset bit clear restores the configuration only
    n_rel = 0;
    write_bytes({8'h66, 8'hd0, 16'h0}, 2);
    check({n_rel[3:0], ref_mode, 2'h0}, {4'h1, 2'b10, 2'h0});
    read_run(1, 16'h0);
    write_bytes({8'h83, 8'ha0, 8'h3c, 8'h00}, 3);
    check(mon_ctrl, 8'ha0);
    // Monitor scan keeps converting after the read ends
    write_bytes({8'h43, 24'h0}, 1);
    host.hi_ext = 400;
    host.bus_start();
    host.put_byte({ADDR, 1'b1}, a);
    host.hi_ext = 0;
    host.get_byte(1'b1, d);
    host.bus_stop();
    repeat (50) @(posedge sys_clk);
    k = n_conv;
    repeat (100) @(posedge sys_clk);
    check({7'h0, seq_busy}, 8'h01);
    check({7'h0, n_conv > k + 2}, 8'h01);
    // Reset in mid-run returns power-on bytes
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check({sda_oe_n, seq_busy, ref_mode, ref_internal_on, clk_ext, shared_pin, 1'b0}, 8'h80);
    check(mon_ctrl, 8'h00);
    read_run(1, 16'h0);
    tally_and_finish();
  end
endmodule // adcs_top_test
